//--- rtl/clk_source_edge.sv
module clk_source_edge #(
    parameter int N_SRC = 4,
    parameter int SEL_BITS = 2
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [N_SRC-1:0]    sources,
    input  wire logic [SEL_BITS-1:0] sel,
    output logic                     edgePulse
);
    typedef struct packed {
        logic prev;
    } edge_state_type;

    edge_state_type s_r;
    edge_state_type s_nxt;
    logic           cur;

    // pick source and flag its rising edge
    always_comb begin
        s_nxt = s_r;
        cur = sources[sel];
        s_nxt.prev = cur;
        edgePulse = cur & ~s_r.prev;
    end

    // previous level of the chosen source
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

//--- rtl/temp_sensor_freq_counter.sv
// Behaviour
// (RQ1) count reference edges, flag match at period
// (RQ2) count sense edges for software readout
// (RQ3) flag clears on written one only
// (RQ4) match interrupt gated by enable bit
// (RQ5) run only enabled; start clears, restarts
// (RQ6) selectable reference and sense sources
// (RQ7) software keeps reference faster than sense
// (RQ8) software supplies reference of 8MHz minimum
// (RQ9) period register read-write, resets all ones
// (RQ10) sense count read-only, resets to zero
// (RQ11) counters freeze at match until restart
module temp_sensor_freq_counter (
    input  wire logic                                 clk,
    input  wire logic                                 rst_b,
    input  wire temp_sensor_pkg::apb_req_type         apbReq,
    output temp_sensor_pkg::apb_rsp_type              apbRsp,
    input  wire logic [temp_sensor_pkg::SRC_N-1:0]    refSources,
    input  wire logic [temp_sensor_pkg::SRC_N-1:0]    senseSources,
    output logic                                      irq
);
    import temp_sensor_pkg::*;

    typedef struct packed {
        apb_rsp_type           rsp;
        logic                  irq;
        meas_state_type        mstate;
        logic                  enable;
        logic                  irqEnable;
        logic                  matchFlag;
        logic [SEL_W-1:0]      refSel;
        logic [SEL_W-1:0]      senseSel;
        logic [PERIOD_W-1:0]   period;
        logic [PERIOD_W-1:0]   refCount;
        logic [COUNT_W-1:0]    senseCount;
        logic [EVT_W-1:0]      status;
        logic [EVT_W-1:0]      mask;
        logic [EVT_W-1:0]      statusSeen;
    } core_state_type;

    // one select line per mapped register
    typedef struct packed {
        logic ctrl;
        logic period;
        logic count;
        logic status;
        logic mask;
    } reg_hit_type;

    core_state_type s_r;
    core_state_type s_nxt;
    logic           refEdge;
    logic           senseEdge;
    logic           setup;
    logic           access;
    logic           matchNow;
    logic [PERIOD_W-1:0] refNext;
    reg_hit_type    hit;

    // sensor_control image as software reads it
    function automatic logic [DATA_W-1:0] ctrlImage(input core_state_type st);
        logic [DATA_W-1:0] v;
        v = DATA_ZERO;
        v[EN_BIT] = st.enable;
        v[FLAG_BIT] = st.matchFlag;
        v[IRQEN_BIT] = st.irqEnable;
        v[REFSEL_LSB +: SEL_W] = st.refSel;
        v[SENSESEL_LSB +: SEL_W] = st.senseSel;
        return v;
    endfunction

    // address to register select, all zero when unmapped
    function automatic reg_hit_type decodeAddr(input logic [ADDR_W-1:0] addr);
        reg_hit_type h;
        h = '0;
        case (addr)
            CTRL_ADDR: begin
                h.ctrl = 1'b1;
            end
            PERIOD_ADDR: begin
                h.period = 1'b1;
            end
            COUNT_ADDR: begin
                h.count = 1'b1;
            end
            STATUS_ADDR: begin
                h.status = 1'b1;
            end
            MASK_ADDR: begin
                h.mask = 1'b1;
            end
            default: begin
                h = '0;
            end
        endcase
        return h;
    endfunction

    // read data of the selected register, zero when unmapped
    function automatic logic [DATA_W-1:0] readImage(input core_state_type st,
                                                     input reg_hit_type    h);
        logic [DATA_W-1:0] v;
        v = DATA_ZERO;
        if (h.ctrl) begin
            v = ctrlImage(st);
        end
        if (h.period) begin
            v[PERIOD_W-1:0] = st.period; // RQ9
        end
        if (h.count) begin
            v[COUNT_W-1:0] = st.senseCount; // RQ10
        end
        if (h.status) begin
            v[EVT_W-1:0] = st.status;
        end
        if (h.mask) begin
            v[EVT_W-1:0] = st.mask;
        end
        return v;
    endfunction

    // control write: fields, flag clear, enable and start
    function automatic core_state_type ctrlWrite(input core_state_type    st,
                                                 input logic [DATA_W-1:0] wd);
        core_state_type n;
        n = st;
        n.enable = wd[EN_BIT]; // RQ5
        n.irqEnable = wd[IRQEN_BIT]; // RQ4
        n.refSel = wd[REFSEL_LSB +: SEL_W]; // RQ6
        n.senseSel = wd[SENSESEL_LSB +: SEL_W]; // RQ6
        if (wd[FLAG_BIT]) begin
            n.matchFlag = 1'b0; // RQ3
        end
        if (!wd[EN_BIT]) begin
            n.mstate = ST_IDLE; // RQ5
        end else if (wd[START_BIT]) begin
            n.refCount = '0; // RQ5
            n.senseCount = COUNT_RESET; // RQ5
            n.mstate = ST_RUN; // RQ5
        end
        return n;
    endfunction

    // reference count equals period; a zero period never matches
    function automatic logic periodReached(input logic [PERIOD_W-1:0] count,
                                           input logic [PERIOD_W-1:0] period);
        return (count == period) && (|period); // RQ1
    endfunction

    // interrupt level from control enable and unmasked events
    function automatic logic irqLevel(input core_state_type st);
        return st.irqEnable & (|(st.status & st.mask)); // RQ4
    endfunction

    // reference source edge
    clk_source_edge #(
        .N_SRC    (SRC_N),
        .SEL_BITS (SEL_W)
    ) refEdgeDet (
        .clk       (clk),
        .rst_b     (rst_b),
        .sources   (refSources),
        .sel       (s_r.refSel),
        .edgePulse (refEdge)
    );

    // sense source edge
    clk_source_edge #(
        .N_SRC    (SRC_N),
        .SEL_BITS (SEL_W)
    ) senseEdgeDet (
        .clk       (clk),
        .rst_b     (rst_b),
        .sources   (senseSources),
        .sel       (s_r.senseSel),
        .edgePulse (senseEdge)
    );

    // bus, measurement and event logic
    always_comb begin
        s_nxt = s_r;
        matchNow = 1'b0;
        refNext = s_r.refCount + PERIOD_ONE;
        setup = apbReq.psel & ~apbReq.penable;
        access = apbReq.psel & apbReq.penable & s_r.rsp.pready;
        hit = decodeAddr(apbReq.paddr);

        // one wait-free access phase after each setup
        s_nxt.rsp.pready = setup;
        s_nxt.rsp.pslverr = 1'b0;
        s_nxt.rsp.prdata = DATA_ZERO;
        if (setup) begin
            s_nxt.statusSeen = EVT_RESET;
            s_nxt.rsp.prdata = readImage(s_r, hit); // RQ9 RQ10
            s_nxt.rsp.pslverr = ~(|hit);
            if (hit.status) begin
                s_nxt.statusSeen = s_r.status;
            end
        end

        // measurement sequence
        case (s_r.mstate)
            ST_IDLE: begin
                s_nxt.mstate = ST_IDLE;
            end
            ST_RUN: begin
                if (refEdge) begin
                    s_nxt.refCount = refNext; // RQ1
                    if (periodReached(refNext, s_r.period)) begin
                        matchNow = 1'b1; // RQ1
                        s_nxt.mstate = ST_DONE; // RQ11
                    end
                end
                if (senseEdge) begin
                    s_nxt.senseCount = s_r.senseCount + COUNT_ONE; // RQ2
                end
            end
            ST_DONE: begin
                s_nxt.mstate = ST_DONE; // RQ11
            end
            default: begin
                s_nxt.mstate = ST_IDLE;
            end
        endcase
        if (!s_r.enable) begin
            s_nxt.mstate = ST_IDLE; // RQ5
        end

        // register writes take effect at the access edge
        if (access && apbReq.pwrite) begin
            if (hit.ctrl) begin
                s_nxt = ctrlWrite(s_nxt, apbReq.pwdata); // RQ3 RQ4 RQ5 RQ6
            end
            if (hit.period) begin
                s_nxt.period = apbReq.pwdata[PERIOD_W-1:0]; // RQ9
            end
            if (hit.mask) begin
                s_nxt.mask = apbReq.pwdata[EVT_W-1:0];
            end
        end

        // read clears only the bits that were reported
        if (access && !apbReq.pwrite && hit.status) begin
            s_nxt.status = s_r.status & ~s_r.statusSeen;
        end

        // a new match wins over any clear
        if (matchNow) begin
            s_nxt.matchFlag = 1'b1; // RQ3
            s_nxt.status[EVT_MATCH] = 1'b1;
        end

        s_nxt.irq = irqLevel(s_nxt); // RQ4
    end

    // single state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r.rsp.prdata <= DATA_ZERO;
            s_r.rsp.pready <= 1'b0;
            s_r.rsp.pslverr <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.mstate <= ST_IDLE;
            s_r.enable <= 1'b0;
            s_r.irqEnable <= 1'b0;
            s_r.matchFlag <= 1'b0;
            s_r.refSel <= REFSEL_RESET;
            s_r.senseSel <= SENSE_OSC_SEL; // RQ6
            s_r.period <= PERIOD_RESET; // RQ9
            s_r.refCount <= '0;
            s_r.senseCount <= COUNT_RESET; // RQ10
            s_r.status <= EVT_RESET;
            s_r.mask <= EVT_RESET;
            s_r.statusSeen <= EVT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign apbRsp = s_r.rsp;
    assign irq = s_r.irq;
endmodule

//--- rtl/temp_sensor_pkg.sv
package temp_sensor_pkg;

    // register byte addresses
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] CTRL_ADDR     = 12'h000;
    localparam logic [11:0] PERIOD_ADDR   = 12'h004;
    localparam logic [11:0] COUNT_ADDR    = 12'h008;
    localparam logic [11:0] STATUS_ADDR   = 12'h00c;
    localparam logic [11:0] MASK_ADDR     = 12'h010;

    // sensor_control fields
    localparam int          EN_BIT        = 0;
    localparam int          START_BIT     = 1;
    localparam int          FLAG_BIT      = 2;
    localparam int          IRQEN_BIT     = 3;
    localparam int          REFSEL_LSB    = 4;
    localparam int          SENSESEL_LSB  = 8;
    localparam int          SEL_W         = 2;
    localparam int          SRC_N         = 4;
    localparam logic [1:0]  REFSEL_RESET  = 2'h0;
    localparam logic [1:0]  SENSE_OSC_SEL = 2'h0;

    // counter widths and reset values
    localparam int           PERIOD_W     = 20;
    localparam int           COUNT_W      = 16;
    localparam logic [19:0]  PERIOD_RESET = 20'hfffff;
    localparam logic [15:0]  COUNT_RESET  = 16'h0000;
    localparam logic [19:0]  PERIOD_ONE   = 20'h00001;
    localparam logic [15:0]  COUNT_ONE    = 16'h0001;

    // event status bits
    localparam int          EVT_W         = 1;
    localparam int          EVT_MATCH     = 0;
    localparam logic [0:0]  EVT_RESET     = 1'h0;

    localparam int          DATA_W        = 32;
    localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } meas_state_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_type;

endpackage

//--- test/temp_sensor_freq_counter_test.sv
module temp_sensor_freq_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import temp_sensor_pkg::*;
    logic        clk;
    logic        rst_b;
    apb_req_type apbReq;
    apb_rsp_type apbRsp;
    logic [3:0]  refSources;
    logic [3:0]  senseSources;
    logic        irq;
    logic [31:0] rdata;
    logic        err;
    int          errorCnt;
    int          totalChecks;
    int          senseQ[$];

    temp_sensor_freq_counter u_temp_sensor_freq_counter (
        .clk(clk),
        .rst_b(rst_b),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .refSources(refSources),
        .senseSources(senseSources),
        .irq(irq)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    task automatic stopTest();
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (apbRsp.pready === 1'b1) break;
        end
        if (n == 20) begin
            errorCnt++;
            $display("wrong value at %0t: no ready", $time);
            stopTest();
        end
        rdata = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rdata, e);
    endtask

    // sense rises in even periods, reference later in every period
    task automatic drive(input int n, input int rs, input int ss);
        for (int k = 0; k < n; k++) begin
            for (int ph = 0; ph < 8; ph++) begin
                @(posedge clk);
                refSources <= ph[2] ? 4'h1 << rs : 4'h0;
                senseSources <= (!ph[2] && !k[0]) ? 4'h1 << ss : 4'h0;
            end
        end
        @(posedge clk);
        refSources <= '0;
        senseSources <= '0;
    endtask

    // one measurement, model expects count of sense edges up to the match
    task automatic run(input int en, input int ie, input int mk);
        int p;
        int rs;
        int ss;
        logic [31:0] c;
        p = 2 + $urandom % 8;
        rs = $urandom % 4;
        ss = $urandom % 4;
        c = ss << 8 | rs << 4 | ie << 3 | en;
        apb(1'b1, PERIOD_ADDR, 32'hfff0_0000 | p);
        rd(PERIOD_ADDR, p);
        apb(1'b1, MASK_ADDR, mk);
        apb(1'b1, CTRL_ADDR, c | 2);
        drive(p + 2, rs, ss);
        if (en) senseQ.push_back((p + 1) / 2);
        chk(irq, ie & en & mk);
        rd(CTRL_ADDR, c | en << 2);
        rd(COUNT_ADDR, senseQ[$]);
        rd(STATUS_ADDR, en);
        rd(STATUS_ADDR, 0);
        chk(irq, 0);
        apb(1'b1, CTRL_ADDR, c);
        rd(CTRL_ADDR, c | en << 2);
        apb(1'b1, CTRL_ADDR, c | 4);
        rd(CTRL_ADDR, c);
    endtask

    // reset, register defaults, then measurements
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        apbReq = '0;
        refSources = '0;
        senseSources = '0;
        errorCnt = 0;
        totalChecks = 0;
        senseQ.push_back(0);
        void'($urandom(31));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(CTRL_ADDR, 0);
        rd(PERIOD_ADDR, 32'h000f_ffff);
        rd(COUNT_ADDR, 0);
        rd(STATUS_ADDR, 0);
        rd(MASK_ADDR, 0);
        apb(1'b1, COUNT_ADDR, '1);
        rd(COUNT_ADDR, 0);
        rd(12'h020, 0);
        chk(err, 1);
        for (int i = 0; i < 4; i++) begin
            run(1, i % 2, i / 2);
        end
        run(0, 1, 1);
        stopTest();
    end
endmodule

//--- test/temp_sensor_monitor.sv
module temp_sensor_monitor (
    input wire logic                         clk,
    input wire logic                         rst_b,
    input wire temp_sensor_pkg::apb_req_type apbReq,
    input wire temp_sensor_pkg::apb_rsp_type apbRsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import temp_sensor_pkg::*;
    logic mapped;
    logic rdAcc;
    // address decode and completed read
    assign mapped = apbReq.paddr inside {CTRL_ADDR, PERIOD_ADDR, COUNT_ADDR,
        STATUS_ADDR, MASK_ADDR};
    assign rdAcc = apbRsp.pready && !apbReq.pwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence setupPh;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence accessPh;
        apbReq.psel && apbReq.penable;
    endsequence
    chk_ready_after_setup: assert property (setupPh |=> apbRsp.pready)
        else $error("no ready after setup");
    chk_ready_in_access: assert property (apbRsp.pready |-> accessPh)
        else $error("ready outside access");
    chk_ready_one_cycle: assert property (setupPh ##1 accessPh |=> !apbRsp.pready)
        else $error("ready held too long");
    chk_err_unmapped: assert property (apbReq.psel && !apbReq.penable && !mapped
        |=> apbRsp.pslverr) else $error("unmapped address accepted");
    chk_err_mapped: assert property (apbRsp.pready && mapped |-> !apbRsp.pslverr)
        else $error("mapped address refused");
    chk_idle_data: assert property (!apbRsp.pready |-> apbRsp.prdata == '0)
        else $error("read data outside access");
    chk_period_width: assert property (rdAcc && apbReq.paddr == PERIOD_ADDR |->
        apbRsp.prdata[31:20] == '0) else $error("period upper bits set");
    chk_count_width: assert property (rdAcc && apbReq.paddr == COUNT_ADDR |->
        apbRsp.prdata[31:16] == '0) else $error("count upper bits set");
    chk_start_reads_zero: assert property (rdAcc && apbReq.paddr == CTRL_ADDR |->
        !apbRsp.prdata[1]) else $error("start bit reads one");
endmodule

bind temp_sensor_freq_counter temp_sensor_monitor u_temp_sensor_monitor (
    .clk(clk),
    .rst_b(rst_b),
    .apbReq(apbReq),
    .apbRsp(apbRsp)
);
